// ### pfh_gpio.sv
// Port F/H general purpose I/O block with AHB-Lite register slave
`timescale 1ns/100ps
module pfh_gpio #(
    parameter int H_BIDIR = 4
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        port_f_pin3_in,
    output logic             port_f_pin3_out,
    output logic             port_f_pin3_oe,
    output logic             conversion_trigger_in,
    output logic             ext_interrupt_in,
    input  wire logic        h_in_pin,
    input  wire logic [5:0]  port_h_in,
    output logic      [5:0]  port_h_out,
    output logic      [5:0]  port_h_oe
);
    // Only the four-pin and six-pin variants are served
    if (H_BIDIR != 4 && H_BIDIR != 6) begin : g_bad_variant
        $error("pfh_gpio: H_BIDIR must be 4 or 6");
    end

    // Mask of implemented port H bidirectional pins
    localparam logic [5:0] H_MASK = (H_BIDIR == 6) ? 6'h3f : 6'h0f;

    logic        pin3_direction_bit;      // Port F direction
    logic        pin3_output_bit;         // Port F latch
    logic [5:0]  port_h_direction;        // Port H direction
    logic [5:0]  port_h_output_latch;     // Port H latch
    logic [1:0]  converter_control_reg;   // Trigger selects
    logic        next_pin3_direction_bit;
    logic        next_pin3_output_bit;
    logic [5:0]  next_port_h_direction;
    logic [5:0]  next_port_h_output_latch;
    logic [1:0]  next_converter_control_reg;
    pfh_pkg::pfh_phase_t phase;           // Bus phase
    pfh_pkg::pfh_phase_t next_phase;
    logic [7:0]  addr_q;                  // Latched address
    logic [7:0]  next_addr_q;
    logic        write_q;                 // Latched direction
    logic        next_write_q;
    logic [31:0] next_hrdata;
    logic        f_pin_s;                 // Synchronised pin 3
    logic [6:0]  h_pin_s;                 // Synchronised port H pins
    logic        next_f_out;
    logic        next_f_oe;
    logic        next_trig;
    logic        next_irq;
    logic [5:0]  next_h_out;
    logic [5:0]  next_h_oe;
    logic        addr_ok;                 // Address phase accepted

    // Pin synchronisers
    pfh_sync #(.WIDTH(1)) u_sync_f (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (port_f_pin3_in),
        .sync_out (f_pin_s)
    );
    pfh_sync #(.WIDTH(7)) u_sync_h (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({h_in_pin, port_h_in}),
        .sync_out (h_pin_s)
    );

    // Pin-state readback: latch when output, pin when input
    function automatic logic [5:0] pin_read(input logic [5:0] dir, input logic [5:0] lat,
                                            input logic [5:0] pin);
        pin_read = (dir & lat) | (~dir & pin);
    endfunction

    assign addr_ok = hsel && hready && htrans[1];

    // Bus phase and address capture
    always_comb begin
        next_phase   = pfh_pkg::PFH_IDLE;
        next_addr_q  = addr_q;
        next_write_q = write_q;
        if (addr_ok) begin
            next_phase   = pfh_pkg::PFH_DATA;
            next_addr_q  = haddr[7:0];
            next_write_q = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase   <= pfh_pkg::PFH_IDLE;
            addr_q  <= 8'h00;
            write_q <= 1'b0;
        end else begin
            phase   <= next_phase;
            addr_q  <= next_addr_q;
            write_q <= next_write_q;
        end
    end

    // Register writes in the data phase
    always_comb begin
        next_pin3_direction_bit    = pin3_direction_bit;
        next_pin3_output_bit       = pin3_output_bit;
        next_port_h_direction      = port_h_direction;
        next_port_h_output_latch   = port_h_output_latch;
        next_converter_control_reg = converter_control_reg;
        if (phase == pfh_pkg::PFH_DATA && write_q) begin
            case (addr_q)
                pfh_pkg::PFH_OFS_F_DIR: begin
                    next_pin3_direction_bit = hwdata[pfh_pkg::PFH_F_PIN3_POS];
                end
                pfh_pkg::PFH_OFS_F_LATCH: begin
                    next_pin3_output_bit = hwdata[pfh_pkg::PFH_F_PIN3_POS];
                end
                pfh_pkg::PFH_OFS_H_DIR: begin
                    next_port_h_direction = hwdata[5:0] & H_MASK;
                end
                pfh_pkg::PFH_OFS_H_LATCH: begin
                    next_port_h_output_latch = hwdata[5:0] & H_MASK;
                end
                pfh_pkg::PFH_OFS_ADC_TRIG: begin
                    next_converter_control_reg = hwdata[1:0];
                end
                default: begin
                    // Pin-state and unmapped writes are dropped
                    next_pin3_output_bit = pin3_output_bit;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin3_direction_bit    <= pfh_pkg::PFH_F_DIR_RST;
            pin3_output_bit       <= pfh_pkg::PFH_F_LATCH_RST;
            port_h_direction      <= pfh_pkg::PFH_H_DIR_RST;
            port_h_output_latch   <= pfh_pkg::PFH_H_LATCH_RST;
            converter_control_reg <= pfh_pkg::PFH_TRIG_RST;
        end else begin
            pin3_direction_bit    <= next_pin3_direction_bit;
            pin3_output_bit       <= next_pin3_output_bit;
            port_h_direction      <= next_port_h_direction;
            port_h_output_latch   <= next_port_h_output_latch;
            converter_control_reg <= next_converter_control_reg;
        end
    end

    // Read data, registered at address phase for the data phase
    always_comb begin
        next_hrdata = pfh_pkg::PFH_UNDEF_READ;
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                pfh_pkg::PFH_OFS_F_LATCH: begin
                    next_hrdata[pfh_pkg::PFH_F_PIN3_POS] = pin3_output_bit;
                end
                pfh_pkg::PFH_OFS_F_PIN: begin
                    next_hrdata[pfh_pkg::PFH_F_PIN3_POS] =
                        pin3_direction_bit ? pin3_output_bit : f_pin_s;
                end
                pfh_pkg::PFH_OFS_H_LATCH: begin
                    next_hrdata[5:0] = port_h_output_latch;
                end
                pfh_pkg::PFH_OFS_H_PIN: begin
                    next_hrdata[5:0] = pin_read(port_h_direction, port_h_output_latch,
                                                h_pin_s[5:0]) & H_MASK;
                    next_hrdata[pfh_pkg::PFH_H_IN_POS] = h_pin_s[6];
                end
                pfh_pkg::PFH_OFS_ADC_TRIG: begin
                    next_hrdata[1:0] = converter_control_reg;
                end
                default: begin
                    // Direction registers are write-only
                    next_hrdata = pfh_pkg::PFH_UNDEF_READ;
                end
            endcase
        end
    end

    // Pin drive and peripheral routing
    always_comb begin
        next_f_oe  = pin3_direction_bit;
        next_f_out = pin3_output_bit;
        next_trig  = converter_control_reg[pfh_pkg::PFH_TRIG_HI_POS] &&
                     converter_control_reg[pfh_pkg::PFH_TRIG_LO_POS] &&
                     !pin3_direction_bit && f_pin_s;
        next_irq   = f_pin_s;
        next_h_oe  = next_port_h_direction & H_MASK;
        next_h_out = next_port_h_output_latch & H_MASK;
    end

    // Output registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata                <= 32'h00000000;
            hreadyout             <= 1'b1;
            hresp                 <= 1'b0;
            port_f_pin3_out       <= 1'b0;
            port_f_pin3_oe        <= 1'b0;
            conversion_trigger_in <= 1'b0;
            ext_interrupt_in      <= 1'b0;
            port_h_out            <= 6'h00;
            port_h_oe             <= 6'h00;
        end else begin
            hrdata                <= next_hrdata;
            hreadyout             <= 1'b1;
            hresp                 <= 1'b0;
            port_f_pin3_out       <= next_pin3_output_bit;
            port_f_pin3_oe        <= next_pin3_direction_bit;
            conversion_trigger_in <= next_trig;
            ext_interrupt_in      <= next_irq;
            port_h_out            <= next_h_out;
            port_h_oe             <= next_h_oe;
        end
    end

    // Checks
    a_f_oe_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == pfh_pkg::PFH_DATA && write_q && addr_q == pfh_pkg::PFH_OFS_F_DIR)
        |=> port_f_pin3_oe == $past(hwdata[pfh_pkg::PFH_F_PIN3_POS]))
        else $error("pin 3 enable wrong");
    a_f_out_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == pfh_pkg::PFH_DATA && write_q && addr_q == pfh_pkg::PFH_OFS_F_LATCH)
        |=> port_f_pin3_out == $past(hwdata[pfh_pkg::PFH_F_PIN3_POS]))
        else $error("pin 3 output wrong");
    a_h_unimpl_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        ((port_h_oe | port_h_out) & ~H_MASK) == 6'h00) else $error("port H extra pin driven");
    a_h_dir_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == pfh_pkg::PFH_DATA && write_q && addr_q == pfh_pkg::PFH_OFS_H_DIR)
        |=> port_h_oe == ($past(hwdata[5:0]) & H_MASK)) else $error("port H dir write lost");
    a_pin_ro: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == pfh_pkg::PFH_DATA && write_q && addr_q == pfh_pkg::PFH_OFS_F_PIN)
        |=> $stable(pin3_output_bit) && $stable(pin3_direction_bit))
        else $error("pin-state write changed state");
    a_dir_unreadable: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr[7:0] == pfh_pkg::PFH_OFS_H_DIR)
        |=> hrdata == pfh_pkg::PFH_UNDEF_READ) else $error("direction readable");
    a_f_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr[7:0] == pfh_pkg::PFH_OFS_F_PIN && pin3_direction_bit)
        |=> hrdata[3] == $past(pin3_output_bit)) else $error("pin 3 readback wrong");
    a_trig_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (converter_control_reg != 2'h3 || pin3_direction_bit) |=> !conversion_trigger_in)
        else $error("trigger leaked");
    a_always_ready: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp) else $error("slave not ready");
    c_f_output: cover property (@(posedge hclk) disable iff (!hresetn) port_f_pin3_oe);
    c_trigger: cover property (@(posedge hclk) disable iff (!hresetn) conversion_trigger_in);
    c_h_write: cover property (@(posedge hclk) disable iff (!hresetn) port_h_oe != 6'h00);
endmodule

// ### pfh_pkg.sv
// Package with register map, field positions and reset values of the port F/H block
package pfh_pkg;
    // Byte offsets of the registers
    localparam logic [7:0] PFH_OFS_F_DIR     = 8'h00;
    localparam logic [7:0] PFH_OFS_F_LATCH   = 8'h04;
    localparam logic [7:0] PFH_OFS_F_PIN     = 8'h08;
    localparam logic [7:0] PFH_OFS_H_DIR     = 8'h0c;
    localparam logic [7:0] PFH_OFS_H_LATCH   = 8'h10;
    localparam logic [7:0] PFH_OFS_H_PIN     = 8'h14;
    localparam logic [7:0] PFH_OFS_ADC_TRIG  = 8'h18;
    // Field positions
    localparam int PFH_F_PIN3_POS  = 3;
    localparam int PFH_H_IN_POS    = 7;
    localparam int PFH_TRIG_LO_POS = 0;
    localparam int PFH_TRIG_HI_POS = 1;
    // Reset values
    localparam logic       PFH_F_DIR_RST   = 1'b0;
    localparam logic       PFH_F_LATCH_RST = 1'b0;
    localparam logic [5:0] PFH_H_DIR_RST   = 6'h00;
    localparam logic [5:0] PFH_H_LATCH_RST = 6'h00;
    localparam logic [1:0] PFH_TRIG_RST    = 2'h0;
    // Value shown for undefined or write-only read bits
    localparam logic [31:0] PFH_UNDEF_READ = 32'h00000000;
    // Bus phase state
    typedef enum logic [1:0] {
        PFH_IDLE = 2'b01,
        PFH_DATA = 2'b10
    } pfh_phase_t;
endpackage

// ### pfh_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pfh_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;  // Only read by stage two
    logic [WIDTH-1:0] stage2;  // Clean copy

    // Two stages, constants at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;
endmodule

// ### pfh_board.sv
// Board model that resolves the port F and port H pin levels
`timescale 1ns/100ps
module pfh_board (
    input  wire logic       f_oe,
    input  wire logic       f_out,
    input  wire logic       f_ext,
    input  wire logic [5:0] h_oe,
    input  wire logic [5:0] h_out,
    input  wire logic [5:0] h_ext,
    output logic            f_pin,
    output logic      [5:0] h_pin
);
    // Board drive yields wherever the block enables its driver
    assign f_pin = f_oe ? f_out : f_ext;
    // Same resolution per port H pin
    assign h_pin = (h_oe & h_out) | (~h_oe & h_ext);
endmodule

// ### port_f_h_gpio_test.sv
// Self-checking bench for the port F/H block
`timescale 1ns/100ps
module port_f_h_gpio_test;
    localparam int HB = 4;                            // Four-pin port H variant
    logic        hclk, hresetn, hsel, hwrite, hready; // Bus control
    logic        hreadyout, hresp;                    // Slave answer
    logic [31:0] haddr, hwdata, hrdata;               // Bus address and data
    logic [1:0]  htrans;                              // Transfer kind
    logic [2:0]  hsize;                               // Transfer size
    logic        f_pin, f_out, f_oe, f_ext, h_in;     // Port F pin and board drive
    logic        trig_out, irq_out;                   // Shared pin functions
    logic [5:0]  h_pin, h_out, h_oe, h_ext, m, hx;    // Port H pins and masks
    logic [31:0] fd, fl, hd, hl, tg, r;               // Random register values
    logic        p;                                   // Expected port F pin level
    logic [7:0]  zr [6];                              // Addresses that read zero
    logic [31:0] hrdata6, r6;                         // Six-pin variant read data
    logic [5:0]  h_pin6, h_out6, h_oe6;               // Six-pin variant port H
    int          error_cnt, checked, cycles;          // Counters

    // Bus clock, 40 ns period
    initial hclk = 1'b0;
    always #20 hclk = ~hclk;
    // Single slave drives the bus ready
    assign hready = hreadyout;

    pfh_gpio #(.H_BIDIR(HB)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_f_pin3_in(f_pin), .port_f_pin3_out(f_out), .port_f_pin3_oe(f_oe),
        .conversion_trigger_in(trig_out), .ext_interrupt_in(irq_out),
        .h_in_pin(h_in), .port_h_in(h_pin), .port_h_out(h_out), .port_h_oe(h_oe));

    pfh_board board (
        .f_oe(f_oe), .f_out(f_out), .f_ext(f_ext), .h_oe(h_oe), .h_out(h_out),
        .h_ext(h_ext), .f_pin(f_pin), .h_pin(h_pin));

    // Six-pin variant on the same bus, always ready like the first
    pfh_gpio #(.H_BIDIR(6)) dut6 (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata6), .hreadyout(), .hresp(),
        .port_f_pin3_in(f_pin), .port_f_pin3_out(), .port_f_pin3_oe(),
        .conversion_trigger_in(), .ext_interrupt_in(),
        .h_in_pin(h_in), .port_h_in(h_pin6), .port_h_out(h_out6), .port_h_oe(h_oe6));

    // Port H pins of the six-pin variant
    pfh_board board6 (
        .f_oe(1'b0), .f_out(1'b0), .f_ext(1'b0), .h_oe(h_oe6), .h_out(h_out6),
        .h_ext(h_ext), .f_pin(), .h_pin(h_pin6));

    // Verdict and end of run
    task results();
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare and report
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One single bus transfer, waits on ready in both phases
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        r6 = hrdata6;
    endtask

    // Pin-state bit: latch when output, pin when input
    function automatic logic [5:0] mix(input logic [5:0] d, l, e);
        return (d & l) | (~d & e);
    endfunction

    // Hang guard
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt++;
            results();
        end
    end

    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, f_ext, h_in} = 5'h0;
        {haddr, hwdata, htrans, h_ext} = '0;
        hsize = 3'b010;
        {error_cnt, checked, cycles} = '0;
        m = (HB == 6) ? 6'h3f : 6'h0f;
        zr = '{pfh_pkg::PFH_OFS_F_DIR, pfh_pkg::PFH_OFS_F_LATCH, pfh_pkg::PFH_OFS_H_DIR,
               pfh_pkg::PFH_OFS_H_LATCH, pfh_pkg::PFH_OFS_ADC_TRIG, 8'h1c};
        r = $urandom(32'hb03eb1d0);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values at the pins
        chk("f_oe_rst", 32'h0, 32'(f_oe));
        chk("h_oe_rst", 32'h0, 32'(h_oe));
        chk("h_out_rst", 32'h0, 32'(h_out));
        chk("h_oe6_rst", 32'h0, 32'(h_oe6));
        // Reset values, write-only and unmapped reads
        foreach (zr[k]) begin
            xfer(1'b0, zr[k], 32'h0, r);
            chk("zero_read", 32'h0, r);
        end
        for (int i = 0; i < 24; i++) begin
            // Corners first, then random values
            fd = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom;
            fl = (i == 0) ? 32'hffffffff : $urandom;
            hd = (i == 0) ? 32'hffffffff : $urandom;
            hl = $urandom;
            // Later odd passes keep the pin for the interrupt alone
            tg = (i < 2) ? 32'h3 : i[0] ? 32'h0 : $urandom;
            f_ext <= 1'($urandom);
            h_ext <= 6'($urandom);
            h_in  <= 1'($urandom);
            xfer(1'b1, pfh_pkg::PFH_OFS_F_DIR, fd, r);
            xfer(1'b1, pfh_pkg::PFH_OFS_F_LATCH, fl, r);
            xfer(1'b1, pfh_pkg::PFH_OFS_H_DIR, hd, r);
            xfer(1'b1, pfh_pkg::PFH_OFS_H_LATCH, hl, r);
            xfer(1'b1, pfh_pkg::PFH_OFS_ADC_TRIG, tg, r);
            // Writes to pin-state registers must be dropped
            xfer(1'b1, pfh_pkg::PFH_OFS_F_PIN, ~fl, r);
            xfer(1'b1, pfh_pkg::PFH_OFS_H_PIN, ~hl, r);
            repeat (3) @(posedge hclk);
            p = fd[3] ? fl[3] : f_ext;
            hx = mix(hd[5:0] & m, hl[5:0], h_ext) & m;
            xfer(1'b0, pfh_pkg::PFH_OFS_F_LATCH, 32'h0, r);
            chk("f_latch", {28'h0, fl[3], 3'h0}, r);
            xfer(1'b0, pfh_pkg::PFH_OFS_F_DIR, 32'h0, r);
            chk("f_dir_read", 32'h0, r);
            xfer(1'b0, pfh_pkg::PFH_OFS_F_PIN, 32'h0, r);
            chk("f_pin_read", {28'h0, p, 3'h0}, r);
            xfer(1'b0, pfh_pkg::PFH_OFS_H_DIR, 32'h0, r);
            chk("h_dir_read", 32'h0, r);
            xfer(1'b0, pfh_pkg::PFH_OFS_H_LATCH, 32'h0, r);
            chk("h_latch", {26'h0, hl[5:0] & m}, r);
            chk("h_latch6", {26'h0, hl[5:0]}, r6);
            xfer(1'b0, pfh_pkg::PFH_OFS_H_PIN, 32'h0, r);
            chk("h_pin_read", {24'h0, h_in, 1'b0, hx}, r);
            chk("h_pin_read6", {24'h0, h_in, 1'b0, mix(hd[5:0], hl[5:0], h_ext)}, r6);
            chk("f_oe", 32'(fd[3]), 32'(f_oe));
            chk("f_out", 32'(fl[3]), 32'(f_out));
            chk("h_oe", 32'(hd[5:0] & m), 32'(h_oe));
            chk("h_out", 32'(hl[5:0] & m), 32'(h_out));
            chk("h_oe6", 32'(hd[5:0]), 32'(h_oe6));
            chk("h_out6", 32'(hl[5:0]), 32'(h_out6));
            chk("trig", 32'((tg[1:0] == 2'b11 && !fd[3]) ? p : 1'b0), 32'(trig_out));
            chk("irq", 32'(p), 32'(irq_out));
        end
        // Second reset in mid-run clears direction and latches
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("h_oe_rst2", 32'h0, 32'(h_oe));
        xfer(1'b0, pfh_pkg::PFH_OFS_F_LATCH, 32'h0, r);
        chk("f_latch_rst2", 32'h0, r);
        results();
    end
endmodule
